// ==== cmds_pkg.sv ====
/*
  constants shared by the contact monitor core: command and status word
  layout, reset values, scan codes and timing counts.
  assumes a 100 mhz system clock.
*/
package cmds_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned GLITCH_NS = 20000;
  localparam int unsigned DEBOUNCE_MS = 5;
  localparam int unsigned WET_PULSE_MS = 20;
  localparam int unsigned POLL_US = 250;
  localparam int unsigned SCAN_UNIT_MS = 1;
  // shortest accepted pulse rounds up
  localparam int unsigned GLITCH_CYCLES = (GLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned WET_PULSE_CYCLES = WET_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned POLL_CYCLES = POLL_US * (CLK_HZ / 1000000);
  localparam int unsigned SCAN_UNIT_CYCLES = SCAN_UNIT_MS * (CLK_HZ / 1000);
  // ==========================================================
  // command word fields
  localparam int CMD_CONT_BIT = 15;
  localparam int CMD_SCAN_HI = 14;
  localparam int CMD_SCAN_LO = 12;
  localparam int CMD_WEN_BIT = 11;
  localparam int CMD_LOW_PAIR_BIT = 10;
  localparam int CMD_UPPER_POL_BIT = 9;
  localparam int CMD_LOWER_POL_BIT = 8;
  localparam int CMD_MASK_HI = 7;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // ==========================================================
  // status word fields
  localparam int STAT_SW_LO = 8;
  localparam int STAT_OT_BIT = 7;
  localparam logic [6:0] STAT_UNUSED = 7'h00;
  // ==========================================================
  // scan period codes
  localparam logic [2:0] SCAN_FIXED_HYSTERESIS_RESISTOR_PIN = 3'h6;
  localparam logic [2:0] SCAN_CONT = 3'h7;
  localparam logic [2:0] SCAN_SLOWEST = 3'h6;
  localparam int NUM_SW = 8;
  localparam int WORD_BITS = 16;

  typedef enum logic [1:0]
  {
    DEB_IDLE = 2'h0,
    DEB_RUN = 2'h1
  } cmds_deb_type;
endpackage

// ==== cmds_core.sv ====
/*
  contact monitor core: glitch filter, shared debounce timer, scan polling,
  wetting-current timing, overheat alert and a 16-bit spi slave.
  assumes comparator outputs and switch levels arrive asynchronously and
  the spi master leaves a few system clocks between cs fall and first clk.
*/
`timescale 1ns/1ps
module cmds_core
#(
  parameter int unsigned DEBOUNCE_CYCLES = cmds_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned WET_PULSE_CYCLES = cmds_pkg::WET_PULSE_CYCLES,
  parameter int unsigned POLL_CYCLES = cmds_pkg::POLL_CYCLES,
  parameter int unsigned SCAN_UNIT_CYCLES = cmds_pkg::SCAN_UNIT_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] switch_inputs_i,
  input wire logic temp_above_trip_i,
  input wire logic temp_below_release_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_n_o,
  output logic change_irq_n_o,
  output logic change_irq_oe_n_o,
  output logic overheat_alert_n_o,
  output logic overheat_alert_oe_n_o,
  output logic direct_level_output_0_o,
  output logic direct_level_output_0_oe_n_o,
  output logic direct_level_output_1_o,
  output logic direct_level_output_1_oe_n_o,
  output logic [7:0] wetting_enable_o,
  output logic [7:0] sense_connect_o,
  output logic [7:0] battery_connected_o,
  output logic fixed_hysteresis_o
);
  // ==========================================================
  // synchronisers
  logic [7:0] sw_s1;
  logic [7:0] sw_s2;
  logic [1:0] temp_s1;
  logic [1:0] temp_s2;
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge clk_sys_i)
  begin
    sw_s1 <= switch_inputs_i;
    sw_s2 <= sw_s1;
    temp_s1 <= {temp_below_release_i, temp_above_trip_i};
    temp_s2 <= temp_s1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end
    else
    begin
      cs_s1 <= spi_cs_n_i;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  assign cs_fall = cs_s3 & ~cs_s2;
  assign cs_rise = ~cs_s3 & cs_s2;

  // ==========================================================
  // command word
  logic [15:0] cmd;
  logic [15:0] spi_shift;
  logic [2:0] scan_code;
  logic cont_sel;
  logic wen;
  logic low_pair_en;
  logic [7:0] irq_mask;
  logic [7:0] battery;
  logic scan_mode;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      cmd <= cmds_pkg::CMD_RESET;
    else if (cs_rise)
      cmd <= spi_shift;
  end

  assign scan_code = cmd[cmds_pkg::CMD_SCAN_HI:cmds_pkg::CMD_SCAN_LO];
  assign cont_sel = cmd[cmds_pkg::CMD_CONT_BIT];
  assign wen = cmd[cmds_pkg::CMD_WEN_BIT];
  assign low_pair_en = cmd[cmds_pkg::CMD_LOW_PAIR_BIT];
  assign irq_mask = cmd[cmds_pkg::CMD_MASK_HI:0];
  // inputs 0-3 are always ground-connected
  assign battery = {{2{cmd[cmds_pkg::CMD_UPPER_POL_BIT]}},
                    {2{cmd[cmds_pkg::CMD_LOWER_POL_BIT]}}, 4'h0};
  assign scan_mode = (scan_code != cmds_pkg::SCAN_FIXED_HYSTERESIS_RESISTOR_PIN) &&
                     (scan_code != cmds_pkg::SCAN_CONT);

  // ==========================================================
  // scan polling
  logic [31:0] scan_cnt;
  logic [31:0] scan_period;
  logic polling;

  always_comb
  begin
    if (scan_code > cmds_pkg::SCAN_SLOWEST)
      scan_period = 32'(SCAN_UNIT_CYCLES);
    else
      scan_period = 32'(SCAN_UNIT_CYCLES) << (cmds_pkg::SCAN_SLOWEST - scan_code);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !scan_mode || scan_cnt >= scan_period - 32'h1)
      scan_cnt <= 32'h0;
    else
      scan_cnt <= scan_cnt + 32'h1;
  end

  assign polling = scan_cnt < 32'(POLL_CYCLES);

  // ==========================================================
  // glitch rejection, one filter per input
  logic [7:0] level_f;
  logic [7:0] closed_f;
  logic sense_on;
  cmds_pkg::cmds_deb_type deb_state;

  // between polls the sense resistors are off, so input levels are stale
  assign sense_on = !scan_mode || polling || (deb_state == cmds_pkg::DEB_RUN);

  genvar gi;
  generate
    for (gi = 0; gi < cmds_pkg::NUM_SW; gi++)
    begin : g_glitch
      logic [15:0] gcnt;
      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          gcnt <= 16'h0;
          level_f[gi] <= ~battery[gi];
        end
        else if (!sense_on || sw_s2[gi] == level_f[gi])
          gcnt <= 16'h0;
        else if (gcnt >= 16'(cmds_pkg::GLITCH_CYCLES - 1))
        begin
          gcnt <= 16'h0;
          level_f[gi] <= sw_s2[gi];
        end
        else
          gcnt <= gcnt + 16'h1;
      end
    end
  endgenerate

  // ground switch closed pulls low, battery switch closed pulls high
  assign closed_f = level_f ^ ~battery;

  // ==========================================================
  // shared debounce timer
  logic [7:0] sw_state;
  logic [7:0] candidate;
  logic [7:0] tracked;
  logic [31:0] deb_cnt;
  logic accept;
  logic [7:0] changed;

  // direct inputs are kept out of the status word
  assign tracked = low_pair_en ? 8'hFF : 8'hFC;
  assign changed = (closed_f ^ sw_state) & tracked;
  assign accept = (deb_state == cmds_pkg::DEB_RUN) &&
                  (deb_cnt >= 32'(DEBOUNCE_CYCLES - 1)) && (changed != 8'h00);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      deb_state <= cmds_pkg::DEB_IDLE;
      deb_cnt <= 32'h0;
      candidate <= 8'h00;
    end
    else
    begin
      case (deb_state)
        cmds_pkg::DEB_IDLE:
        begin
          deb_cnt <= 32'h0;
          candidate <= closed_f;
          if (sense_on && changed != 8'h00)
            deb_state <= cmds_pkg::DEB_RUN;
        end
        cmds_pkg::DEB_RUN:
        begin
          if (changed == 8'h00)
            deb_state <= cmds_pkg::DEB_IDLE;
          else if (accept)
            deb_state <= cmds_pkg::DEB_IDLE;
          else if ((closed_f & tracked) != (candidate & tracked))
          begin
            // one timer for all inputs: a fresh change restarts it
            candidate <= closed_f;
            deb_cnt <= 32'h0;
          end
          else
            deb_cnt <= deb_cnt + 32'h1;
        end
        default:
          deb_state <= cmds_pkg::DEB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      sw_state <= 8'h00;
    else if (accept)
      sw_state <= (sw_state & ~tracked) | (candidate & tracked);
    else if (!low_pair_en)
      sw_state[1:0] <= 2'h0;
  end

  // ==========================================================
  // change interrupt, open drain
  logic irq_event;

  assign irq_event = accept && ((changed & ~irq_mask) != 8'h00);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      change_irq_oe_n_o <= 1'b1;
    else if (irq_event)
      change_irq_oe_n_o <= 1'b0;
    else if (cs_fall)
      change_irq_oe_n_o <= 1'b1;
  end

  // ==========================================================
  // overheat
  logic hot;
  logic hot_d;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      hot <= 1'b0;
      hot_d <= 1'b0;
    end
    else
    begin
      hot_d <= hot;
      if (temp_s2[0])
        hot <= 1'b1;
      else if (temp_s2[1])
        hot <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      overheat_alert_oe_n_o <= 1'b1;
    else if (hot && !hot_d)
      overheat_alert_oe_n_o <= 1'b0;
    else if (cs_fall)
      overheat_alert_oe_n_o <= 1'b1;
  end

  // ==========================================================
  // wetting current
  logic [31:0] wet_cnt;
  logic wet_pulse;
  logic wet_time;
  logic [7:0] wet_allowed;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      wet_cnt <= 32'h0;
    else if (accept)
      wet_cnt <= 32'(WET_PULSE_CYCLES);
    else if (wet_cnt != 32'h0)
      wet_cnt <= wet_cnt - 32'h1;
  end

  assign wet_pulse = wet_cnt != 32'h0;
  assign wet_time = (cont_sel || wet_pulse) && (!scan_mode || polling);
  // protection only matters while global wetting is on
  assign wet_allowed = (wen && !hot) ? (low_pair_en ? 8'hFF : 8'hFC) : 8'h00;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wetting_enable_o <= 8'h00;
      sense_connect_o <= 8'h00;
      battery_connected_o <= 8'h00;
      fixed_hysteresis_o <= 1'b0;
    end
    else
    begin
      wetting_enable_o <= wet_time ? (wet_allowed & sw_state) : 8'h00;
      sense_connect_o <= sense_on ? (low_pair_en ? 8'hFF : 8'hFC) : 8'h00;
      battery_connected_o <= battery;
      fixed_hysteresis_o <= scan_code == cmds_pkg::SCAN_FIXED_HYSTERESIS_RESISTOR_PIN;
    end
  end

  // ==========================================================
  // direct level outputs
  logic direct_on;

  assign direct_on = !low_pair_en && !scan_mode;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      direct_level_output_0_o <= 1'b0;
      direct_level_output_1_o <= 1'b0;
      direct_level_output_0_oe_n_o <= 1'b1;
      direct_level_output_1_oe_n_o <= 1'b1;
    end
    else
    begin
      direct_level_output_0_o <= sw_s2[0];
      direct_level_output_1_o <= sw_s2[1];
      direct_level_output_0_oe_n_o <= ~direct_on;
      direct_level_output_1_oe_n_o <= ~direct_on;
    end
  end

  // ==========================================================
  // spi slave, system side
  logic [15:0] snapshot;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      snapshot <= 16'h0000;
      spi_sdo_oe_n_o <= 1'b1;
      change_irq_n_o <= 1'b0;
      overheat_alert_n_o <= 1'b0;
    end
    else
    begin
      if (cs_fall)
        snapshot <= {sw_state, hot, cmds_pkg::STAT_UNUSED};
      spi_sdo_oe_n_o <= cs_s2;
      change_irq_n_o <= 1'b0;
      overheat_alert_n_o <= 1'b0;
    end
  end

  // ==========================================================
  // spi slave, link side
  // snapshot and spi_shift are stable whenever the other side reads them
  logic [3:0] bit_idx;

  always_ff @(posedge spi_clk_i)
  begin
    if (spi_cs_n_i)
      bit_idx <= 4'h0;
    else
    begin
      spi_sdo_o <= snapshot[4'hF - bit_idx];
      bit_idx <= bit_idx + 4'h1;
    end
  end

  always_ff @(negedge spi_clk_i)
  begin
    if (!spi_cs_n_i)
      spi_shift <= {spi_shift[14:0], spi_sdi_i};
  end
endmodule

// ==== cmds_core_props.sv ====
/*
  port-level checker for the contact monitor core.
  assumes it is bound onto every cmds_core instance.
*/
`timescale 1ns/1ps
module cmds_core_props
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] switch_inputs_i,
  input wire logic temp_above_trip_i,
  input wire logic temp_below_release_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdo_oe_n_o,
  input wire logic change_irq_oe_n_o,
  input wire logic overheat_alert_oe_n_o,
  input wire logic direct_level_output_0_o,
  input wire logic direct_level_output_0_oe_n_o,
  input wire logic [7:0] wetting_enable_o,
  input wire logic [7:0] sense_connect_o,
  input wire logic [7:0] battery_connected_o
);
  // ==========================================================
  // port relations
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // margins cover the three-flop cs synchroniser
  AST_IRQ_CS_REL:
    assert property ($fell(spi_cs_n_i) |-> ##[1:5] change_irq_oe_n_o) else $error("irq kept");
  AST_OT_CS_REL:
    assert property ($fell(spi_cs_n_i) |-> ##[1:5] overheat_alert_oe_n_o) else $error("alert kept");
  AST_IRQ_HOLD:
    assert property (spi_cs_n_i[*4] ##0 !change_irq_oe_n_o |=> !change_irq_oe_n_o)
    else $error("irq dropped");
  AST_SDO_REL:
    assert property (spi_cs_n_i[*4] |-> spi_sdo_oe_n_o) else $error("sdo driven");
  AST_SDO_DRV:
    assert property ((!spi_cs_n_i)[*4] |-> !spi_sdo_oe_n_o) else $error("sdo not driven");
  AST_WET_HOT:
    assert property (temp_above_trip_i[*6] |-> wetting_enable_o == 8'h00) else $error("wet hot");
  AST_ALERT_SET:
    assert property ((temp_below_release_i && !temp_above_trip_i)[*4] ##1
      (temp_above_trip_i && spi_cs_n_i)[*6] |-> !overheat_alert_oe_n_o) else $error("no alert");
  AST_DO_FOLLOW:
    assert property ((!direct_level_output_0_oe_n_o && switch_inputs_i[0])[*4]
      |-> direct_level_output_0_o) else $error("direct lag");
  AST_DIRECT_OFF:
    assert property ((!direct_level_output_0_oe_n_o)[*3] |->
      (sense_connect_o[1:0] == 2'h0) && (wetting_enable_o[1:0] == 2'h0)) else $error("pair on");
  AST_BATT_LOW:
    assert property (battery_connected_o[3:0] == 4'h0) else $error("low nibble polarity");
  cover property ($fell(change_irq_oe_n_o));
  cover property ($fell(overheat_alert_oe_n_o));
  cover property (!direct_level_output_0_oe_n_o);
endmodule

bind cmds_core cmds_core_props props_u
(
  .clk_sys_i(clk_sys_i),
  .rst_i(rst_i),
  .switch_inputs_i(switch_inputs_i),
  .temp_above_trip_i(temp_above_trip_i),
  .temp_below_release_i(temp_below_release_i),
  .spi_cs_n_i(spi_cs_n_i),
  .spi_sdo_oe_n_o(spi_sdo_oe_n_o),
  .change_irq_oe_n_o(change_irq_oe_n_o),
  .overheat_alert_oe_n_o(overheat_alert_oe_n_o),
  .direct_level_output_0_o(direct_level_output_0_o),
  .direct_level_output_0_oe_n_o(direct_level_output_0_oe_n_o),
  .wetting_enable_o(wetting_enable_o),
  .sense_connect_o(sense_connect_o),
  .battery_connected_o(battery_connected_o)
);

// ==== cmds_spi_master.sv ====
/*
  behavioural spi master on the far side of the link.
  assumes mode 1, a 160 ns link clock and sdi pulled low when idle.
*/
`timescale 1ns/1ps
module cmds_spi_master
(
  output logic spi_clk_o,
  output logic spi_cs_n_o,
  output logic spi_sdi_o,
  input wire logic spi_sdo_i,
  output logic [15:0] rx_word_o,
  output logic rx_done_o
);
  // ==========================================================
  // frame engine
  initial
  begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_sdi_o = 1'b0;
    rx_word_o = 16'h0000;
    rx_done_o = 1'b0;
    // the slave bit counter has no reset, one idle edge clears it
    #37 spi_clk_o = 1'b1;
    #80 spi_clk_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx);
    spi_cs_n_o = 1'b0;
    #103;
    for (int i = 15; i >= 0; i--)
    begin
      spi_clk_o = 1'b1;
      spi_sdi_o = tx[i];
      #80;
      spi_clk_o = 1'b0;
      rx_word_o[i] = spi_sdo_i;
      #80;
    end
    spi_cs_n_o = 1'b1;
    spi_sdi_o = 1'b0;
    #200;
    rx_done_o = 1'b1;
    #20;
    rx_done_o = 1'b0;
  endtask
endmodule

// ==== contact_monitor_debounce_spi_tb_top.sv ====
/*
  self-checking bench for the contact monitor core.
  assumes shortened timing parameters and the behavioural spi master.
*/
`timescale 1ns/1ps
module contact_monitor_debounce_spi_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sw = 8'hFF;
  logic trip = 1'b0;
  logic cool = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n, irq_oe_n, ot_oe_n, do0, do0_oe_n, done, hysteresis_resistor_pin;
  logic [7:0] wet, batt, sense;
  logic [15:0] rx;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int checked = 0;
  wire sdo_line = sdo_oe_n ? 1'bz : sdo;
  always #5 clk_sys_i = ~clk_sys_i;
  // ==========================================================
  // instances
  // a poll must outlast the 2000 cycle glitch filter or scan mode never sees a change
  cmds_core #(.DEBOUNCE_CYCLES(50), .WET_PULSE_CYCLES(200), .POLL_CYCLES(2500),
    .SCAN_UNIT_CYCLES(3000)) dut_u
  (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .switch_inputs_i(sw), .temp_above_trip_i(trip),
    .temp_below_release_i(cool), .spi_clk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi),
    .spi_sdo_o(sdo), .spi_sdo_oe_n_o(sdo_oe_n), .change_irq_n_o(),
    .change_irq_oe_n_o(irq_oe_n), .overheat_alert_n_o(), .overheat_alert_oe_n_o(ot_oe_n),
    .direct_level_output_0_o(do0), .direct_level_output_0_oe_n_o(do0_oe_n),
    .direct_level_output_1_o(), .direct_level_output_1_oe_n_o(), .wetting_enable_o(wet),
    .sense_connect_o(sense), .battery_connected_o(batt), .fixed_hysteresis_o(hysteresis_resistor_pin)
  );
  cmds_spi_master spi_u
  (
    .spi_clk_o(sclk), .spi_cs_n_o(cs_n), .spi_sdi_o(sdi), .spi_sdo_i(sdo_line),
    .rx_word_o(rx), .rx_done_o(done)
  );
  // ==========================================================
  // tasks
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic xfer(input logic [15:0] tx, input logic [15:0] e);
    exp_q.push_back(e);
    spi_u.xfer(tx);
    repeat (6) @(negedge clk_sys_i);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_oe_n !== 1'b0 && n < 2400)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("irq wait", 16'h0, 16'(irq_oe_n));
    if (irq_oe_n !== 1'b0)
      finish_test();
  endtask
  task automatic wait_sense(input logic [7:0] v);
    int n;
    n = 0;
    while (sense !== v && n < 7000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("sense connect", 16'(v), 16'(sense));
    if (sense !== v)
      finish_test();
  endtask
  // ==========================================================
  // read monitor, oldest note first
  always @(posedge done)
  begin
    chk("status word", exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX, rx);
  end
  initial
  begin
    #900000;
    err_count++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    checked = $urandom(16228);
    checked = 0;
    idle(12);
    rst_i = 1'b0;
    idle(4);
    chk("reset wetting", 16'h0, 16'(wet));
    chk("reset direct", 16'h1, 16'(do0_oe_n));
    for (int c = 0; c < 8; c++)
    begin
      xfer({1'b1, c[2:0], 12'h800}, 16'h0000);
      chk("fixed hysteresis", 16'(c == 6), 16'(hysteresis_resistor_pin));
      chk("direct enable", 16'(c >= 6), 16'(!do0_oe_n));
    end
    sw[0] = 1'b0;
    idle(2200);
    chk("direct output", 16'h0, 16'(do0));
    chk("direct irq", 16'h1, 16'(irq_oe_n));
    sw[0] = 1'b1;
    // filter must settle before the pair leaves direct use
    idle(2200);
    xfer(16'hFC00, 16'h0000);
    // glitch stays under the 2000 cycle filter
    sw[5] = 1'b0;
    idle(200 + $urandom % 1500);
    sw[5] = 1'b1;
    idle(2200);
    chk("glitch irq", 16'h1, 16'(irq_oe_n));
    sw[3] = 1'b0;
    wait_irq();
    idle(3);
    chk("wetting closed", 16'h08, 16'(wet));
    xfer(16'hFC10, 16'h0800);
    chk("irq released", 16'h1, 16'(irq_oe_n));
    sw[4] = 1'b0;
    idle(2200);
    chk("masked irq", 16'h1, 16'(irq_oe_n));
    cool = 1'b0;
    trip = 1'b1;
    idle(10);
    chk("alert", 16'h0, 16'(ot_oe_n));
    chk("wetting hot", 16'h0, 16'(wet));
    xfer(16'hFC10, 16'h1880);
    chk("alert released", 16'h1, 16'(ot_oe_n));
    trip = 1'b0;
    cool = 1'b1;
    idle(10);
    chk("wetting cooled", 16'h18, 16'(wet));
    // scan code 5 with continuous wetting, input 4 still masked
    xfer(16'hDC10, 16'h1800);
    wait_sense(8'h00);
    chk("wetting between polls", 16'h0, 16'(wet));
    wait_sense(8'hFF);
    chk("wetting in poll", 16'h18, 16'(wet));
    // change at poll start so the filter completes inside the poll
    sw[2] = 1'b0;
    wait_irq();
    wait_sense(8'h00);
    xfer(16'hFF10, 16'h1C00);
    chk("irq released scan", 16'h1, 16'(irq_oe_n));
    chk("polarity", 16'hF0, 16'(batt));
    // second reset mid-run must clear the command word again
    rst_i = 1'b1;
    idle(12);
    rst_i = 1'b0;
    idle(4);
    chk("reset polarity", 16'h0, 16'(batt));
    chk("reset wetting again", 16'h0, 16'(wet));
    xfer(16'h0000, 16'h0000);
    idle(20);
    finish_test();
  end
endmodule
